// ==== shared/scc_gate_if.sv ====
`timescale 1ns/1ns
interface scc_gate_if;
  logic src;
  logic halt_n;
  logic halve;
  logic out;

  modport ctrl (output src, output halt_n, output halve, input out);
  modport gate (input src, input halt_n, input halve, output out);
endinterface

// ==== shared/scc_pkg.sv ====
package scc_pkg;

  // Register map
  localparam logic [7:0] REG_LO_ADDR  = 8'h00;
  localparam logic [7:0] REG_HI_ADDR  = 8'h01;
  localparam logic [7:0] REG_CMD_ADDR = 8'hF0;

  // Opcodes, matched on the low nibble only
  localparam logic [3:0] OP_INC   = 4'h1;
  localparam logic [3:0] OP_DEC   = 4'h2;
  localparam logic [3:0] OP_APPLY = 4'h4;
  localparam logic [3:0] OP_FETCH = 4'h8;

  // Fixed part of the 7-bit slave address (10110b)
  localparam logic [4:0] SLAVE_PREFIX = 5'h16;

  // High register field positions
  localparam int HI_FB_MSB    = 7;
  localparam int HI_FB_LSB    = 6;
  localparam int HI_FIRST_MSB = 5;
  localparam int HI_FIRST_LSB = 3;
  localparam int HI_HALVE_BIT = 2;
  localparam int HI_PRE_BIT   = 1;
  localparam int HI_LOCK_BIT  = 0;

  // Startup configuration when the configuration pins float
  localparam logic [9:0] FB_RESET    = 10'h1F4;
  localparam logic [2:0] FIRST_RESET = 3'h2;
  localparam logic       HALVE_RESET = 1'b0;
  localparam logic       PRE_RESET   = 1'b1;

  // Bits in one I2C byte and lock qualification delay in clock cycles
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam int         LOCK_DELAY_CYC = 1024;

  typedef struct packed {
    logic [9:0] fb_ratio;
    logic [2:0] first_out_ratio;
    logic       second_out_halving;
    logic       pre_div;
  } scc_div_t;

  localparam scc_div_t DIV_RESET = '{FB_RESET, FIRST_RESET, HALVE_RESET, PRE_RESET};

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_TX_ACK
  } scc_i2c_st_t;

endpackage

// ==== verification/scc_i2c_host.sv ====
`timescale 1ns/1ns
module scc_i2c_host
(
  // Line level
  input  wire logic i_sda,
  // Clock level and data pull-down
  output logic      o_scl,
  output logic      o_sda_low
);
  // Clock rests high between frames
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // Data moves only mid-way through the low phase, never while the clock is high
  task automatic bit_cycle(input logic drv_low, output logic seen);
    #31;
    o_sda_low = drv_low;
    #32;
    o_scl = 1'b1;
    #62;
    seen = i_sda;
    o_scl = 1'b0;
  endtask

  task automatic start();
    o_sda_low = 1'b1;
    #62;
    o_scl = 1'b0;
  endtask

  task automatic stop();
    #31;
    o_sda_low = 1'b1;
    #32;
    o_scl = 1'b1;
    #62;
    o_sda_low = 1'b0;
    #125;
  endtask

  // A read passes 8'hFF so the line is left to the device
  task automatic xfer(input logic [7:0] tx, input logic ack_out,
                      output logic [7:0] rx, output logic ack_in);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cycle(~tx[i], b);
      rx[i] = b;
    end
    bit_cycle(ack_out, b);
    ack_in = ~b;
  endtask
endmodule

// ==== verification/synth_config_i2c_control_tb.sv ====
`timescale 1ns/1ns
module synth_config_i2c_control_tb;
  import scc_pkg::*;
  localparam int unsigned LOCK_N = 8;
  logic        i_clk, i_rst_b, i_scl, i_sda, o_sda_out, o_sda_oe, sda_low, junk;
  logic        i_addr_strap_hi, i_addr_strap_lo, i_pin_config_sel_n, i_pll_lock_raw;
  logic        i_synth_clk, o_second_out_halving, o_pre_div, o_lock, m_lock;
  logic        i_output_halt_n_a, i_output_halt_n_b, o_clock_out_a, o_clock_out_b;
  logic [9:0]  o_fb_ratio;
  logic [2:0]  o_first_out_ratio;
  logic [7:0]  m_lo, m_hi, t;
  logic [15:0] rnd_state;
  logic [3:0]  ops [7];
  scc_div_t    pin_cfg, m_act;
  int          err_total, comparisons, ca, cb;

  scc_synth_cfg #(.LOCK_DELAY(LOCK_N)) DUT
  (
    .i_clk, .i_rst_b, .i_scl, .i_sda, .o_sda_out, .o_sda_oe, .i_addr_strap_hi,
    .i_addr_strap_lo, .i_pin_config_sel_n, .i_pin_fb_ratio(pin_cfg.fb_ratio),
    .i_pin_first_out_ratio(pin_cfg.first_out_ratio), .i_pin_pre_div(pin_cfg.pre_div),
    .i_pin_second_out_halving(pin_cfg.second_out_halving), .i_pll_lock_raw, .i_synth_clk,
    .o_fb_ratio, .o_first_out_ratio, .o_second_out_halving, .o_pre_div, .o_lock,
    .i_output_halt_n_a, .i_output_halt_n_b, .o_clock_out_a, .o_clock_out_b
  );
  scc_i2c_host host (.i_sda, .o_scl(i_scl), .o_sda_low(sda_low));
  // Open drain with pull-up: either side pulling low wins
  assign i_sda = ~(sda_low | (o_sda_oe & ~o_sda_out));

  always #5 i_clk = ~i_clk;
  always
  begin
    #62 i_synth_clk = ~i_synth_clk;
    #63 i_synth_clk = ~i_synth_clk;
  end

  function automatic logic [7:0] rnd8();
    rnd_state = {rnd_state[14:0], ^(rnd_state & 16'hB400)};
    return rnd_state[7:0];
  endfunction

  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask

  task automatic chk_v(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic chk_d(input string what, input scc_div_t exp);
    scc_div_t got;
    got = {o_fb_ratio, o_first_out_ratio, o_second_out_halving, o_pre_div};
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic mirror();
    {m_hi[7:6], m_lo, m_hi[5:1]} = m_act;
    m_hi[0] = 1'b0;
  endtask

  task automatic model_wr(input logic [7:0] ra, input logic [7:0] d);
    if (i_pin_config_sel_n === 1'b0)
      return;
    if (ra === REG_LO_ADDR)
      m_lo = d;
    if (ra === REG_HI_ADDR)
      m_hi = d & 8'hFE;
    if (ra === REG_CMD_ADDR)
      case (d[3:0])
        OP_INC:   m_act.fb_ratio = m_act.fb_ratio + 10'h001;
        OP_DEC:   m_act.fb_ratio = m_act.fb_ratio - 10'h001;
        OP_APPLY: m_act = {m_hi[7:6], m_lo, m_hi[5:1]};
        OP_FETCH: mirror();
        default:  ;
      endcase
  endtask

  task automatic i2c_write(input logic [7:0] q[$]);
    logic [7:0] rx;
    logic       ack;
    host.start();
    host.xfer({SLAVE_PREFIX, i_addr_strap_hi, i_addr_strap_lo, 1'b0}, 1'b0, rx, ack);
    chk_v("write addr ack", 8'h01, {7'h00, ack});
    foreach (q[i])
    begin
      host.xfer(q[i], 1'b0, rx, ack);
      chk_v("byte ack", 8'h01, {7'h00, ack});
    end
    host.stop();
    repeat (4) tick();
    for (int i = 0; i + 1 < q.size(); i += 2)
      model_wr(q[i], q[i + 1]);
  endtask

  task automatic addr_probe(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] rx;
    logic       ack;
    host.start();
    host.xfer({SLAVE_PREFIX, a, 1'b0}, 1'b0, rx, ack);
    host.stop();
    chk_v("addr match", exp, {7'h00, ack});
  endtask

  task automatic check_regs(input string what);
    logic [7:0] lo, hi, a;
    logic       k;
    host.start();
    host.xfer({SLAVE_PREFIX, i_addr_strap_hi, i_addr_strap_lo, 1'b1}, 1'b0, a, k);
    host.xfer(8'hFF, 1'b1, lo, k);
    host.xfer(8'hFF, 1'b0, hi, k);
    host.stop();
    chk_v(what, m_lo, lo);
    chk_v(what, {m_hi[7:1], m_lock}, hi);
  endtask

  task automatic do_reset(input logic sel_n);
    tick();
    i_rst_b = 1'b0;
    i_pin_config_sel_n = sel_n;
    repeat (2) tick();
    i_rst_b = 1'b1;
    repeat (5) tick();
    m_act = pin_cfg;
    mirror();
    m_lock = 1'b0;
    chk_d("startup", m_act);
    check_regs("startup regs");
  endtask

  task automatic wait_lock(input logic exp, input int lim);
    int n;
    n = 0;
    while (o_lock !== exp && n < lim)
    begin
      tick();
      n++;
    end
    chk_v("lock", {7'h00, exp}, {7'h00, o_lock});
    if (n == lim)
      complete_run();
  endtask

  task automatic count_rises();
    logic pa, pb;
    ca = 0;
    cb = 0;
    pa = o_clock_out_a;
    pb = o_clock_out_b;
    repeat (800)
    begin
      tick();
      ca += int'(o_clock_out_a === 1'b1 && pa === 1'b0);
      cb += int'(o_clock_out_b === 1'b1 && pb === 1'b0);
      pa = o_clock_out_a;
      pb = o_clock_out_b;
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #900000;
    err_total++;
    complete_run();
  end

  initial
  begin
    i_clk = 1'b0;
    i_synth_clk = 1'b0;
    i_rst_b = 1'b0;
    {i_addr_strap_hi, i_addr_strap_lo} = 2'b10;
    i_pll_lock_raw = 1'b0;
    i_output_halt_n_a = 1'b0;
    i_output_halt_n_b = 1'b0;
    i_pin_config_sel_n = 1'b0;
    err_total = 0;
    comparisons = 0;
    rnd_state = 16'hEA79;
    ops = '{OP_APPLY, OP_INC, OP_DEC, OP_DEC, 4'h3, 4'h0, OP_FETCH};
    {junk, pin_cfg} = {rnd8(), rnd8()};
    do_reset(1'b0);
    pin_cfg = DIV_RESET;
    do_reset(1'b1);
    chk_d("default", DIV_RESET);
    $display("test startup done");
    t = rnd8();
    i2c_write('{REG_HI_ADDR, rnd8() | 8'h01, REG_LO_ADDR, t, 8'h05, rnd8()});
    chk_d("write only", m_act);
    check_regs("written");
    foreach (ops[k])
    begin
      // Steps come only after the apply has set a full configuration
      t = rnd8();
      i2c_write('{REG_CMD_ADDR, {t[7:4], ops[k]}});
      chk_d("command", m_act);
      if (k == 1)
        check_regs("after step");
    end
    check_regs("fetched");
    i2c_write('{REG_LO_ADDR, 8'hFF, REG_HI_ADDR, 8'hC0,
                REG_CMD_ADDR, 8'h04, REG_CMD_ADDR, 8'h01});
    chk_d("wrap", m_act);
    $display("test commands done");
    for (int s = 0; s < 4; s++)
    begin
      tick();
      {i_addr_strap_hi, i_addr_strap_lo} = 2'(s);
      addr_probe(2'(s), 8'h01);
      addr_probe(2'(s) ^ 2'b01, 8'h00);
    end
    $display("test address done");
    tick();
    {junk, pin_cfg} = {rnd8(), rnd8()};
    i_pin_config_sel_n = 1'b0;
    repeat (5) tick();
    m_act = pin_cfg;
    mirror();
    chk_d("pin mode", m_act);
    i2c_write('{REG_LO_ADDR, rnd8(), REG_CMD_ADDR, 8'h01});
    chk_d("pin write", m_act);
    check_regs("pin mirror");
    i_pin_config_sel_n = 1'b1;
    {junk, pin_cfg} = {rnd8(), rnd8()};
    repeat (5) tick();
    chk_d("to serial", m_act);
    check_regs("to serial");
    $display("test modes done");
    i_pll_lock_raw = 1'b1;
    repeat (6) tick();
    chk_v("lock early", 8'h00, {7'h00, o_lock});
    wait_lock(1'b1, 10);
    m_lock = 1'b1;
    check_regs("lock bit");
    i_pll_lock_raw = 1'b0;
    wait_lock(1'b0, 4);
    m_lock = 1'b0;
    $display("test lock done");
    i2c_write('{REG_HI_ADDR, m_hi | 8'h04, REG_CMD_ADDR, 8'h04});
    i_output_halt_n_a = 1'b1;
    i_output_halt_n_b = 1'b1;
    count_rises();
    chk_v("halved", 8'h01, {7'h00, ca > 50 && cb * 2 >= ca - 2 && cb * 2 <= ca + 2});
    i_output_halt_n_a = 1'b0;
    repeat (40) tick();
    count_rises();
    chk_v("halted", 8'h01, {7'h00, ca == 0 && cb > 20 && o_clock_out_a === 1'b0});
    $display("test clocks done");
    complete_run();
  end
endmodule

// ==== verilog/scc_clk_gate.sv ====
`timescale 1ns/1ns
module scc_clk_gate
  import scc_pkg::*;
(
  // Clock and reset
  input wire logic  i_clk,
  input wire logic  i_rst_b,
  // Gated output path
  scc_gate_if.gate  gi
);

  logic src_q;
  logic div;
  logic run;
  logic out;
  logic next_src_q;
  logic next_div;
  logic next_run;
  logic next_out;
  logic lvl;

  always_comb
  begin
    next_src_q = gi.src;
    next_div   = div;
    // Divider free-runs through halts so shared rising edges stay aligned
    if (gi.src && !src_q)
    begin
      next_div = ~div;
    end
    lvl      = gi.halve ? next_div : gi.src;
    next_run = run;
    // Enable changes only while the clock is low, so no runt pulse
    if (!lvl)
    begin
      next_run = gi.halt_n;
    end
    next_out = lvl & next_run;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      src_q <= 1'b0;
      div   <= 1'b0;
      run   <= 1'b0;
      out   <= 1'b0;
    end
    else
    begin
      src_q <= next_src_q;
      div   <= next_div;
      run   <= next_run;
      out   <= next_out;
    end
  end

  assign gi.out = out;

  a_halt_stays_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!out && !gi.halt_n && !run) |=> !out)
    else $error("halted output produced a pulse");

endmodule

// ==== verilog/scc_synth_cfg.sv ====
`timescale 1ns/1ns
module scc_synth_cfg
  import scc_pkg::*;
#(
  parameter int unsigned LOCK_DELAY = LOCK_DELAY_CYC
)
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Serial interface
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  input  wire logic       i_addr_strap_hi,
  input  wire logic       i_addr_strap_lo,
  // Pin configuration
  input  wire logic       i_pin_config_sel_n,
  input  wire logic [9:0] i_pin_fb_ratio,
  input  wire logic [2:0] i_pin_first_out_ratio,
  input  wire logic       i_pin_second_out_halving,
  input  wire logic       i_pin_pre_div,
  // PLL side
  input  wire logic       i_pll_lock_raw,
  input  wire logic       i_synth_clk,
  output logic [9:0]      o_fb_ratio,
  output logic [2:0]      o_first_out_ratio,
  output logic            o_second_out_halving,
  output logic            o_pre_div,
  output logic            o_lock,
  // Output clocks
  input  wire logic       i_output_halt_n_a,
  input  wire logic       i_output_halt_n_b,
  output logic            o_clock_out_a,
  output logic            o_clock_out_b
);

  localparam int LW = $clog2(LOCK_DELAY + 1);
  localparam logic [LW-1:0] LOCK_LAST = LW'(LOCK_DELAY - 1);
  localparam int SW = 24;

  // Two-flop synchronisers for every pin; only stage two is read
  logic [SW-1:0] sync_meta;
  logic [SW-1:0] sync_s;
  logic          scl_s;
  logic          sda_s;
  logic [1:0]    strap_s;
  logic          sel_n_s;
  scc_div_t      pin_div;
  logic          lock_raw_s;
  logic          synth_s;
  logic [1:0]    halt_n_s;

  always_ff @(posedge i_clk)
  begin
    sync_meta <= {i_scl, i_sda, i_addr_strap_hi, i_addr_strap_lo, i_pin_config_sel_n,
                  i_pin_fb_ratio, i_pin_first_out_ratio, i_pin_second_out_halving,
                  i_pin_pre_div, i_pll_lock_raw, i_synth_clk, i_output_halt_n_a,
                  i_output_halt_n_b};
    sync_s    <= sync_meta;
  end

  assign {scl_s, sda_s, strap_s, sel_n_s, pin_div, lock_raw_s, synth_s, halt_n_s} = sync_s;

  function automatic scc_div_t regs_to_div(input logic [7:0] lo, input logic [7:1] hi);
    scc_div_t d;
    d.fb_ratio           = {hi[HI_FB_MSB:HI_FB_LSB], lo};
    d.first_out_ratio    = hi[HI_FIRST_MSB:HI_FIRST_LSB];
    d.second_out_halving = hi[HI_HALVE_BIT];
    d.pre_div            = hi[HI_PRE_BIT];
    return d;
  endfunction

  function automatic logic [7:1] div_to_hi(input scc_div_t d);
    logic [7:1] h;
    h = {d.fb_ratio[9:8], d.first_out_ratio, d.second_out_halving, d.pre_div};
    return h;
  endfunction

  // ---------------- Serial slave ----------------
  scc_i2c_st_t st;
  scc_i2c_st_t next_st;
  logic        scl_q;
  logic        sda_q;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [7:0]  rx_sh;
  logic [7:0]  next_rx_sh;
  logic [7:0]  tx_sh;
  logic [7:0]  next_tx_sh;
  logic        oe;
  logic        next_oe;
  logic        rd;
  logic        next_rd;
  logic        tx_hi;
  logic        next_tx_hi;
  logic        wr_phase;
  logic        next_wr_phase;
  logic [7:0]  reg_ptr;
  logic [7:0]  next_reg_ptr;
  logic        wr_stb;
  logic        next_wr_stb;
  logic [7:0]  wr_addr;
  logic [7:0]  next_wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  next_wr_data;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        addr_match;
  logic [7:0]  cfg_lo;
  logic [7:1]  cfg_hi;
  logic        lock;
  logic [7:0]  rd_lo;
  logic [7:0]  rd_hi;

  assign scl_rise   = scl_s & ~scl_q;
  assign scl_fall   = ~scl_s & scl_q;
  assign bus_start  = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop   = scl_s & scl_q & ~sda_q & sda_s;
  assign addr_match = (rx_sh[7:1] == {SLAVE_PREFIX, strap_s});
  // Only the two configuration registers are ever sent back
  assign rd_lo      = cfg_lo;
  assign rd_hi      = {cfg_hi, lock};

  always_comb
  begin
    next_st       = st;
    next_cnt      = cnt;
    next_rx_sh    = rx_sh;
    next_tx_sh    = tx_sh;
    next_oe       = oe;
    next_rd       = rd;
    next_tx_hi    = tx_hi;
    next_wr_phase = wr_phase;
    next_reg_ptr  = reg_ptr;
    next_wr_stb   = 1'b0;
    next_wr_addr  = wr_addr;
    next_wr_data  = wr_data;
    if (bus_stop)
    begin
      next_st = ST_IDLE;
      next_oe = 1'b0;
    end
    else if (bus_start)
    begin
      next_st       = ST_ADDR;
      next_cnt      = 4'h0;
      next_oe       = 1'b0;
      next_wr_phase = 1'b0;
    end
    else if (scl_rise)
    begin
      case (st)
        ST_ADDR, ST_RX:
        begin
          next_rx_sh = {rx_sh[6:0], sda_s};
          next_cnt   = cnt + 4'h1;
        end
        ST_TX:
        begin
          next_cnt = cnt + 4'h1;
        end
        ST_TX_ACK:
        begin
          // A not-acknowledge ends the read
          if (sda_s)
          begin
            next_st = ST_IDLE;
          end
        end
        default:
        begin
          next_st = st;
        end
      endcase
    end
    else if (scl_fall)
    begin
      case (st)
        ST_ADDR:
        begin
          if (cnt == BYTE_BITS)
          begin
            if (addr_match)
            begin
              next_st    = ST_ACK;
              next_oe    = 1'b1;
              next_rd    = rx_sh[0];
              next_tx_hi = 1'b0;
            end
            else
            begin
              next_st = ST_IDLE;
            end
          end
        end
        ST_RX:
        begin
          if (cnt == BYTE_BITS)
          begin
            // Every byte is acked, even in pin mode or to unknown addresses
            next_st = ST_ACK;
            next_oe = 1'b1;
            if (!wr_phase)
            begin
              next_reg_ptr = rx_sh;
            end
            else
            begin
              next_wr_stb  = 1'b1;
              next_wr_addr = reg_ptr;
              next_wr_data = rx_sh;
            end
            next_wr_phase = ~wr_phase;
          end
        end
        ST_ACK:
        begin
          next_cnt = 4'h0;
          if (rd)
          begin
            next_st    = ST_TX;
            next_tx_sh = rd_lo;
            next_oe    = ~rd_lo[7];
          end
          else
          begin
            next_st = ST_RX;
            next_oe = 1'b0;
          end
        end
        ST_TX:
        begin
          if (cnt == BYTE_BITS)
          begin
            next_st    = ST_TX_ACK;
            next_oe    = 1'b0;
            next_tx_hi = ~tx_hi;
          end
          else
          begin
            next_tx_sh = {tx_sh[6:0], 1'b0};
            next_oe    = ~tx_sh[6];
          end
        end
        ST_TX_ACK:
        begin
          next_st    = ST_TX;
          next_cnt   = 4'h0;
          next_tx_sh = tx_hi ? rd_hi : rd_lo;
          next_oe    = tx_hi ? ~rd_hi[7] : ~rd_lo[7];
        end
        default:
        begin
          next_st = st;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      st       <= ST_IDLE;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      cnt      <= 4'h0;
      rx_sh    <= 8'h00;
      tx_sh    <= 8'h00;
      oe       <= 1'b0;
      rd       <= 1'b0;
      tx_hi    <= 1'b0;
      wr_phase <= 1'b0;
      reg_ptr  <= 8'h00;
      wr_stb   <= 1'b0;
      wr_addr  <= 8'h00;
      wr_data  <= 8'h00;
    end
    else
    begin
      st       <= next_st;
      scl_q    <= scl_s;
      sda_q    <= sda_s;
      cnt      <= next_cnt;
      rx_sh    <= next_rx_sh;
      tx_sh    <= next_tx_sh;
      oe       <= next_oe;
      rd       <= next_rd;
      tx_hi    <= next_tx_hi;
      wr_phase <= next_wr_phase;
      reg_ptr  <= next_reg_ptr;
      wr_stb   <= next_wr_stb;
      wr_addr  <= next_wr_addr;
      wr_data  <= next_wr_data;
    end
  end

  // ---------------- Configuration ----------------
  scc_div_t   act;
  scc_div_t   next_act;
  logic [7:0] next_cfg_lo;
  logic [7:1] next_cfg_hi;
  logic       boot_done;
  logic       boot;
  logic       serial;

  assign boot   = ~boot_done;
  assign serial = sel_n_s;

  always_comb
  begin
    next_act    = act;
    next_cfg_lo = cfg_lo;
    next_cfg_hi = cfg_hi;
    if (boot || !serial)
    begin
      // Synchronisers run through reset, so pins are valid at release
      next_act    = pin_div;
      next_cfg_lo = pin_div.fb_ratio[7:0];
      next_cfg_hi = div_to_hi(pin_div);
    end
    else if (wr_stb)
    begin
      // Mode switch into serial touches nothing here
      case (wr_addr)
        REG_LO_ADDR:
        begin
          next_cfg_lo = wr_data;
        end
        REG_HI_ADDR:
        begin
          next_cfg_hi = wr_data[7:1];
        end
        REG_CMD_ADDR:
        begin
          // Results are applied unchecked, even outside the lock range
          case (wr_data[3:0])
            OP_INC:   next_act.fb_ratio = act.fb_ratio + 10'h001;
            OP_DEC:   next_act.fb_ratio = act.fb_ratio - 10'h001;
            OP_APPLY: next_act = regs_to_div(cfg_lo, cfg_hi);
            OP_FETCH:
            begin
              next_cfg_lo = act.fb_ratio[7:0];
              next_cfg_hi = div_to_hi(act);
            end
            default:  next_act = act;
          endcase
        end
        default:
        begin
          next_act = act;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      act       <= DIV_RESET;
      cfg_lo    <= FB_RESET[7:0];
      cfg_hi    <= div_to_hi(DIV_RESET);
      boot_done <= 1'b0;
    end
    else
    begin
      act       <= next_act;
      cfg_lo    <= next_cfg_lo;
      cfg_hi    <= next_cfg_hi;
      boot_done <= 1'b1;
    end
  end

  // ---------------- Lock qualification ----------------
  logic [LW-1:0] lock_cnt;
  logic [LW-1:0] next_lock_cnt;
  logic          next_lock;

  always_comb
  begin
    next_lock_cnt = lock_cnt;
    next_lock     = lock;
    if (!lock_raw_s)
    begin
      next_lock_cnt = '0;
      next_lock     = 1'b0;
    end
    else if (lock_cnt == LOCK_LAST)
    begin
      next_lock = 1'b1;
    end
    else
    begin
      next_lock_cnt = lock_cnt + LW'(1);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      lock_cnt <= '0;
      lock     <= 1'b0;
    end
    else
    begin
      lock_cnt <= next_lock_cnt;
      lock     <= next_lock;
    end
  end

  // ---------------- Output clocks ----------------
  scc_gate_if gate_bus[2] ();

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_out
      assign gate_bus[gi].src    = synth_s;
      assign gate_bus[gi].halt_n = halt_n_s[1-gi];
      assign gate_bus[gi].halve  = (gi == 1) ? act.second_out_halving : 1'b0;
      scc_clk_gate u_gate (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .gi      (gate_bus[gi])
      );
    end
  endgenerate

  assign o_clock_out_a        = gate_bus[0].out;
  assign o_clock_out_b        = gate_bus[1].out;
  assign o_sda_out            = 1'b0;
  assign o_sda_oe             = oe;
  assign o_fb_ratio           = act.fb_ratio;
  assign o_first_out_ratio    = act.first_out_ratio;
  assign o_second_out_halving = act.second_out_halving;
  assign o_pre_div            = act.pre_div;
  assign o_lock               = lock;

  // ---------------- Checks ----------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_cmd(logic [3:0] op);
    boot_done && serial && wr_stb && wr_addr == REG_CMD_ADDR && wr_data[3:0] == op;
  endsequence

  a_inc_step: assert property (
    s_cmd(OP_INC) |=> act.fb_ratio == $past(act.fb_ratio) + 10'h001)
    else $error("increment did not add one");
  a_dec_step: assert property (
    s_cmd(OP_DEC) |=> act.fb_ratio == $past(act.fb_ratio) - 10'h001)
    else $error("decrement did not subtract one");
  a_apply_copy: assert property (
    s_cmd(OP_APPLY) |=> act == regs_to_div($past(cfg_lo), $past(cfg_hi)))
    else $error("apply did not copy registers");
  a_fetch_copy: assert property (
    s_cmd(OP_FETCH) |=> cfg_lo == $past(act.fb_ratio[7:0]) && cfg_hi == div_to_hi($past(act)))
    else $error("fetch did not copy dividers");
  a_step_regs_keep: assert property (
    (s_cmd(OP_INC) or s_cmd(OP_DEC)) |=> $stable(cfg_lo) && $stable(cfg_hi))
    else $error("step changed config registers");
  a_write_no_act: assert property (
    (boot_done && serial && wr_stb && wr_addr != REG_CMD_ADDR) |=> $stable(act))
    else $error("register write changed dividers");
  a_pin_follow: assert property (
    (!serial) |=> act == $past(pin_div) && cfg_lo == $past(pin_div.fb_ratio[7:0]))
    else $error("pin mode dividers not following pins");
  a_lock_drop: assert property ((!lock_raw_s) |=> !o_lock)
    else $error("lock not dropped at once");
  a_lock_delay: assert property ($rose(o_lock) |-> $past(lock_cnt) == LOCK_LAST && $past(lock_raw_s))
    else $error("lock raised before delay");
  a_addr_ack: assert property (
    (st == ST_ADDR && scl_fall && cnt == BYTE_BITS && !bus_start && !bus_stop && !addr_match)
    |=> st == ST_IDLE && !o_sda_oe)
    else $error("foreign address acknowledged");

endmodule
